/* File: common/ccsp_pkg.sv */
package ccsp_pkg;

  // Converter clock and derived times
  localparam int CLK_PERIOD_NS   = 10;
  localparam int RELOCK_PULSE_NS = 1000;
  localparam int DLL_LOCK_NS     = 5000;
  localparam int DLL_LOCK_CYC    = DLL_LOCK_NS / CLK_PERIOD_NS;
  localparam logic [9:0] DLL_LOCK_LAST = 10'(DLL_LOCK_CYC - 1);

  // Serial frame layout, most significant bit first
  localparam logic [4:0] FRAME_BITS   = 5'h10;
  localparam logic [4:0] HDR_LAST_CNT = 5'h07;
  localparam logic [4:0] DATA_CNT     = 5'h08;
  localparam logic [4:0] FRAME_LAST   = 5'h0f;
  localparam int         FR_RNW       = 15;
  localparam int         FR_ADDR_HI   = 9;
  localparam int         FR_ADDR_LO   = 8;
  localparam int         HDR_RNW      = 7;

  // Register addresses
  localparam logic [1:0] ADDR_CTRL    = 2'h0;
  localparam logic [1:0] ADDR_PAT_HI  = 2'h1;
  localparam logic [1:0] ADDR_PAT_LO  = 2'h2;
  localparam logic [1:0] ADDR_RESET   = 2'h0;

  // Reset values
  localparam logic [7:0] CTRL_RESET   = 8'h08;
  localparam logic [5:0] PAT_HI_RESET = 6'h00;
  localparam logic [7:0] PAT_LO_RESET = 8'h00;

  // Operating mode codes
  localparam logic [1:0] MODE_NORMAL  = 2'h0;
  localparam logic [1:0] MODE_FIXED   = 2'h1;
  localparam logic [1:0] MODE_USER    = 2'h2;

  // Output word constants
  localparam logic [13:0] FIXED_PATTERN = 14'h298e;
  localparam logic [13:0] WORD_ZERO     = 14'h0000;

  // Device control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic [1:0] operating_mode_field;
    logic       lane_config_sel;
    logic       duty_stabilizer_on;
    logic       twos_complement_sel;
    logic       word_align_sel;
    logic       powerdown_chan_a;
    logic       powerdown_chan_b;
  } ccsp_ctrl_s;

  // Direct control pins and serial select, as seen by the sync stage
  typedef struct packed {
    logic       serial_select_n;
    logic       serial_enable;
    logic       dll_relock;
    logic       test_pin;
    logic [1:0] format_stabilizer_pin;
    logic       lane_config_sel;
    logic       word_align_sel;
    logic       powerdown_chan_a;
    logic       powerdown_chan_b;
  } ccsp_pins_s;

  // Pin levels held in the filter during reset: select released, rest low
  localparam ccsp_pins_s PINS_IDLE = '{serial_select_n: 1'b1, default: '0};

  // One channel's result from the converter core
  typedef struct packed {
    logic [13:0] word;
    logic        over;
  } ccsp_chan_s;

  typedef enum logic [1:0] {
    DLL_COUNT,
    DLL_LOCKED,
    DLL_LOST,
    DLL_HOLD
  } ccsp_dll_e;

endpackage : ccsp_pkg

/* File: src/ccsp_top.sv */
// What this block does
// R1: Each power-down input powers down only its own channel; output invalid.
// R2: Host pulses relock input high about 1 us after abrupt clock change.
// R3: Lane pin high sends one lane per channel, low splits over two.
// R4: Test pin high sends fixed pattern 10100110001110 MSB first.
// R5: Alignment pin: low half-word offset, high aligned; low in single-lane.
// R6: Serial enable high uses registers, low uses the direct pins.
// R7: Serial port works only while the converter clock runs.
// R8: Each access is 16 serial clocks inside one chip-select assertion.
// R9: SDI sampled on rising SCLK, SDO changes on falling SCLK.
// R10: Chip select rising before the 16th clock discards the access.
// R11: Chip select rising after full access latches address and writes.
// R12: First bit 1 reads, 0 writes; reserved bits zero; three registers.
// R13: Second byte is write data; ignored on reads.
// R14: SDO released outside select; read data on last 8 falling edges.
// R15: Held register address is 00h after reset.
// R16: Mode bits 7:6 pick normal, fixed, user pattern, reserved.
// R17: Bit 5 high sends on lane one only, lane zero released.
// R18: Bit 4 turns stabilizer on; bit 3 selects two's complement.
// R19: Bit 2 in dual-lane delays lane one a cycle for aligned words.
// R20: Bit 1 powers down channel A, bit 0 channel B.
// R21: Address 1h holds pattern bits 13:8 in bits 5:0; 7:6 reserved.
// R22: Overrange output follows channel result each output word.
// R23: Lock output high while locked, low after lock is lost.
// R24: Address 2h holds pattern low byte, reset zero.
// R25: Frame is sent MSB first: direction, reserved, address, data.
`timescale 1ns/1ns
module ccsp_top (
  // Converter clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rst,
  // Serial port link
  input  wire logic                  sclk,
  input  wire logic                  sdi,
  input  wire logic                  serial_select_n,
  output logic                       sdo,
  output logic                       sdo_oe,
  // Direct control pins
  input  wire ccsp_pkg::ccsp_pins_s  pins,
  // Converter core side
  input  wire logic                  word_strobe,
  input  wire ccsp_pkg::ccsp_chan_s  chan_in [2],
  input  wire logic                  lock_lost_evt,
  // Effective controls and status
  output ccsp_pkg::ccsp_ctrl_s       eff_ctrl,
  output logic [1:0]                 held_addr,
  output logic                       dll_lock,
  output logic [1:0]                 overrange,
  // Serial data lanes, index 0 is channel A
  output logic [1:0]                 lane_one_out,
  output logic [1:0]                 lane_zero_out,
  output logic [1:0]                 lane_zero_oe
);
  import ccsp_pkg::*;

  localparam int DLL_MAX = 503;

  // Serial clock domain state
  logic [4:0]  cnt_reg;
  logic [14:0] sh_reg;
  logic [7:0]  hdr_reg;
  logic [15:0] frame_reg;
  logic        done_tgl_reg;
  logic        sdo_reg;
  logic        sdo_oe_reg;

  // Converter clock domain state
  ccsp_pins_s  p1_reg, p2_reg, p3_reg, pf_reg, pf_next;
  logic        t1_reg, t2_reg, t3_reg;
  logic        cs_prev_reg;
  logic        pending_reg;
  ccsp_ctrl_s  ctrl_reg;
  logic [5:0]  pat_hi_reg;
  logic [7:0]  pat_lo_reg;
  logic [1:0]  held_addr_reg;
  ccsp_ctrl_s  eff_reg, eff_next;
  ccsp_dll_e   dll_state_reg, dll_state_next;
  logic [9:0]  dll_cnt_reg;
  logic        dll_lock_reg;

  // Frame bit counter and shifter, cleared while select is high
  always_ff @(posedge sclk or posedge serial_select_n) begin
    if (serial_select_n) begin
      cnt_reg <= 5'h00;
      sh_reg  <= 15'h0000;
      hdr_reg <= 8'h00;
    end else begin
      sh_reg <= {sh_reg[13:0], sdi};                        // [R9] [R25]
      if (cnt_reg != FRAME_BITS) begin
        cnt_reg <= cnt_reg + 5'h01;                         // [R8]
      end
      if (cnt_reg == HDR_LAST_CNT) begin
        hdr_reg <= {sh_reg[6:0], sdi};
      end
    end
  end

  // Whole frame captured on the 16th rising edge, signalled by a toggle
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      frame_reg    <= 16'h0000;
      done_tgl_reg <= 1'b0;
    end else if (!serial_select_n && cnt_reg == FRAME_LAST) begin
      frame_reg    <= {sh_reg, sdi};                        // [R8]
      done_tgl_reg <= ~done_tgl_reg;
    end
  end

  // Read data; registers only change while select is high, so they are
  // static for the whole frame and safe to sample from the serial side
  wire [1:0] rd_addr = hdr_reg[1:0];
  wire [7:0] rd_byte = (rd_addr == ADDR_CTRL)   ? ctrl_reg :
                       (rd_addr == ADDR_PAT_HI) ? {2'h0, pat_hi_reg} :
                       (rd_addr == ADDR_PAT_LO) ? pat_lo_reg : 8'h00;
  wire       rd_active = hdr_reg[HDR_RNW] && cnt_reg >= DATA_CNT &&
                         cnt_reg <= FRAME_LAST;
  wire [2:0] rd_bit = 3'(FRAME_LAST - cnt_reg);

  // Output side of the port, falling edges only
  always_ff @(negedge sclk or posedge serial_select_n) begin
    if (serial_select_n) begin
      sdo_reg    <= 1'b0;                                   // [R14]
      sdo_oe_reg <= 1'b0;                                   // [R14]
    end else begin
      sdo_oe_reg <= 1'b1;
      sdo_reg    <= rd_active ? rd_byte[rd_bit] : 1'b0;     // [R9] [R14]
    end
  end

  assign sdo    = sdo_reg;
  assign sdo_oe = sdo_oe_reg;

  // Pin filter: a bit changes once the second and third stages agree
  assign pf_next = (p2_reg & ~(p2_reg ^ p3_reg)) | (pf_reg & (p2_reg ^ p3_reg));

  always_ff @(posedge mclk) begin
    if (rst) begin
      p1_reg <= PINS_IDLE;
      p2_reg <= PINS_IDLE;
      p3_reg <= PINS_IDLE;
      pf_reg <= PINS_IDLE;
    end else begin
      p1_reg <= {serial_select_n, pins[8:0]};
      p2_reg <= p1_reg;
      p3_reg <= p2_reg;
      pf_reg <= pf_next;
    end
  end

  // Frame-done toggle brought over to the converter clock
  always_ff @(posedge mclk) begin
    if (rst) begin
      t1_reg <= 1'b0;
      t2_reg <= 1'b0;
      t3_reg <= 1'b0;
    end else begin
      t1_reg <= done_tgl_reg;
      t2_reg <= t1_reg;
      t3_reg <= t2_reg;
    end
  end

  // Access events; the port needs the converter clock running
  wire frame_done = t2_reg ^ t3_reg;                        // [R7]
  wire cs_rise    = pf_reg.serial_select_n && !cs_prev_reg;
  wire cs_fall    = !pf_reg.serial_select_n && cs_prev_reg;
  wire commit     = cs_rise && (pending_reg || frame_done); // [R10] [R11]
  wire wr_commit  = commit && !frame_reg[FR_RNW];           // [R12] [R13]
  wire [1:0] fr_addr = frame_reg[FR_ADDR_HI:FR_ADDR_LO];
  wire [7:0] fr_data = frame_reg[7:0];

  // Pending flag: a finished frame wins over a new frame start
  always_ff @(posedge mclk) begin
    if (rst) begin
      cs_prev_reg <= 1'b1;
      pending_reg <= 1'b0;
    end else begin
      cs_prev_reg <= pf_reg.serial_select_n;
      if (frame_done) begin
        pending_reg <= 1'b1;
      end else if (cs_fall || commit) begin
        pending_reg <= 1'b0;                                // [R10]
      end
    end
  end

  // Register bank, written on select rising after a full frame
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_reg      <= CTRL_RESET;
      pat_hi_reg    <= PAT_HI_RESET;
      pat_lo_reg    <= PAT_LO_RESET;
      held_addr_reg <= ADDR_RESET;                          // [R15]
    end else begin
      if (commit) begin
        held_addr_reg <= fr_addr;                           // [R11]
      end
      if (wr_commit && fr_addr == ADDR_CTRL) begin
        ctrl_reg <= fr_data;                                // [R11] [R13]
      end
      if (wr_commit && fr_addr == ADDR_PAT_HI) begin
        pat_hi_reg <= fr_data[5:0];                         // [R21]
      end
      if (wr_commit && fr_addr == ADDR_PAT_LO) begin
        pat_lo_reg <= fr_data;                              // [R24]
      end
    end
  end

  // Effective controls: registers when the port is enabled, else pins
  always_comb begin
    if (pf_reg.serial_enable) begin
      eff_next = ctrl_reg;                                  // [R6]
    end else begin
      eff_next.operating_mode_field = pf_reg.test_pin ? MODE_FIXED
                                                      : MODE_NORMAL; // [R4]
      eff_next.lane_config_sel     = pf_reg.lane_config_sel;         // [R3]
      eff_next.duty_stabilizer_on  = pf_reg.format_stabilizer_pin[0];
      eff_next.twos_complement_sel = pf_reg.format_stabilizer_pin[1];
      eff_next.word_align_sel      = pf_reg.word_align_sel;          // [R5]
      eff_next.powerdown_chan_a    = pf_reg.powerdown_chan_a;        // [R1]
      eff_next.powerdown_chan_b    = pf_reg.powerdown_chan_b;        // [R1]
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      eff_reg <= CTRL_RESET;
    end else begin
      eff_reg <= eff_next;                                  // [R6]
    end
  end

  assign eff_ctrl  = eff_reg;                               // [R18]
  assign held_addr = held_addr_reg;

  // Lock tracker: lost on an abrupt clock change, regained after relock
  always_comb begin
    dll_state_next = dll_state_reg;
    case (dll_state_reg)
      DLL_COUNT:  if (dll_cnt_reg == DLL_LOCK_LAST) begin
                    dll_state_next = DLL_LOCKED;
                  end
      DLL_LOCKED: if (lock_lost_evt) begin
                    dll_state_next = DLL_LOST;              // [R23]
                  end
      DLL_LOST:   dll_state_next = DLL_LOST;
      DLL_HOLD:   if (!pf_reg.dll_relock) begin
                    dll_state_next = DLL_COUNT;
                  end
      default:    dll_state_next = DLL_COUNT;
    endcase
    if (pf_reg.dll_relock) begin
      dll_state_next = DLL_HOLD;                            // [R2]
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      dll_state_reg <= DLL_COUNT;
      dll_cnt_reg   <= 10'h000;
      dll_lock_reg  <= 1'b0;
    end else begin
      dll_state_reg <= dll_state_next;
      dll_cnt_reg   <= (dll_state_reg == DLL_COUNT) ?
                       dll_cnt_reg + 10'h001 : 10'h000;
      dll_lock_reg  <= (dll_state_next == DLL_LOCKED);      // [R23]
    end
  end

  assign dll_lock = dll_lock_reg;

  // Per-channel word select and lane serializer
  wire [13:0] user_word = {pat_hi_reg, pat_lo_reg};
  wire [1:0]  chan_pd   = {eff_reg.powerdown_chan_b, eff_reg.powerdown_chan_a};
  wire        single    = eff_reg.lane_config_sel;
  wire        aligned   = eff_reg.word_align_sel && !single;

  for (genvar g = 0; g < 2; g++) begin : g_chan
    logic [13:0] sh_word_reg;
    logic        dly_reg, l1_reg, l0_reg, oe_reg, or_reg;
    wire  [13:0] fmt_word = eff_reg.twos_complement_sel ?
                 {~chan_in[g].word[13], chan_in[g].word[12:0]} :
                 chan_in[g].word;                           // [R18]
    wire  [13:0] sel_word =
      chan_pd[g] ? WORD_ZERO :                              // [R1] [R20]
      (eff_reg.operating_mode_field == MODE_FIXED) ? FIXED_PATTERN :
      (eff_reg.operating_mode_field == MODE_USER)  ? user_word :
      (eff_reg.operating_mode_field == MODE_NORMAL) ? fmt_word :
      WORD_ZERO;                                            // [R4] [R16]
    wire  [13:0] shifted = single ? {sh_word_reg[12:0], 1'b0} :
                 {sh_word_reg[12:7], 1'b0, sh_word_reg[5:0], 1'b0};

    always_ff @(posedge mclk) begin
      if (rst) begin
        sh_word_reg <= WORD_ZERO;
        dly_reg     <= 1'b0;
        l1_reg      <= 1'b0;
        l0_reg      <= 1'b0;
        oe_reg      <= 1'b0;
        or_reg      <= 1'b0;
      end else begin
        sh_word_reg <= word_strobe ? sel_word : shifted;    // [R3]
        dly_reg     <= sh_word_reg[13];
        l1_reg      <= aligned ? dly_reg : sh_word_reg[13]; // [R19] [R5]
        l0_reg      <= single ? 1'b0 : sh_word_reg[6];      // [R3]
        oe_reg      <= !single;                             // [R17]
        if (word_strobe) begin
          or_reg <= chan_in[g].over && !chan_pd[g];         // [R22]
        end
      end
    end

    assign lane_one_out[g]  = l1_reg;
    assign lane_zero_out[g] = l0_reg;
    assign lane_zero_oe[g]  = oe_reg;
    assign overrange[g]     = or_reg;

    property p_fixed_word;
      @(posedge mclk) disable iff (rst)
      word_strobe && !chan_pd[g] &&
      eff_reg.operating_mode_field == MODE_FIXED
      |=> sh_word_reg == 14'h298e;
    endproperty
    a_fixed_word: assert property (p_fixed_word)      // [R4]
      else $error("fixed pattern not loaded");

    property p_overrange;
      @(posedge mclk) disable iff (rst)
      word_strobe && !chan_pd[g] |=> or_reg == $past(chan_in[g].over);
    endproperty
    a_overrange: assert property (p_overrange)        // [R22]
      else $error("overrange not updated on word");
  end

  // Checks on the converter clock side
  property p_write_ctrl;
    @(posedge mclk) disable iff (rst)
    wr_commit && fr_addr == ADDR_CTRL |=> ctrl_reg == $past(fr_data);
  endproperty
  a_write_ctrl: assert property (p_write_ctrl)        // [R11]
    else $error("control register not written");

  property p_discard;
    @(posedge mclk) disable iff (rst)
    cs_rise && !pending_reg && !frame_done |=>
      $stable(ctrl_reg) && $stable(pat_lo_reg) && $stable(held_addr_reg);
  endproperty
  a_discard: assert property (p_discard)              // [R10]
    else $error("short access changed state");

  property p_read_no_write;
    @(posedge mclk) disable iff (rst)
    commit && frame_reg[FR_RNW] |=> $stable(ctrl_reg) && $stable(pat_hi_reg);
  endproperty
  a_read_no_write: assert property (p_read_no_write)  // [R13]
    else $error("read access wrote a register");

  property p_addr_reset;
    @(posedge mclk) rst |=> held_addr_reg == 2'h0 && ctrl_reg == 8'h08;
  endproperty
  a_addr_reset: assert property (p_addr_reset)        // [R15]
    else $error("reset values wrong");

  property p_reg_pd;
    @(posedge mclk) disable iff (rst)
    pf_reg.serial_enable |=> eff_reg.powerdown_chan_a == $past(ctrl_reg[1])
                          && eff_reg.powerdown_chan_b == $past(ctrl_reg[0]);
  endproperty
  a_reg_pd: assert property (p_reg_pd)                // [R20]
    else $error("register power-down not applied");

  property p_pin_ctrl;
    @(posedge mclk) disable iff (rst)
    !pf_reg.serial_enable |=>
      eff_reg.powerdown_chan_a == $past(pf_reg.powerdown_chan_a) &&
      eff_reg.lane_config_sel == $past(pf_reg.lane_config_sel);
  endproperty
  a_pin_ctrl: assert property (p_pin_ctrl)            // [R6]
    else $error("direct pins not applied");

  property p_single_lane;
    @(posedge mclk) disable iff (rst)
    single [*2] |-> !lane_zero_oe[0] && !lane_zero_oe[1];
  endproperty
  a_single_lane: assert property (p_single_lane)      // [R17]
    else $error("lane zero driven in single-lane mode");

  property p_lock_lost;
    @(posedge mclk) disable iff (rst)
    dll_lock_reg && lock_lost_evt && !pf_reg.dll_relock
      |=> !dll_lock_reg [*3];
  endproperty
  a_lock_lost: assert property (p_lock_lost)          // [R23]
    else $error("lock not dropped");

  property p_relock;
    @(posedge mclk) disable iff (rst)
    $fell(pf_reg.dll_relock) && !lock_lost_evt
      |-> ##[1:DLL_MAX] dll_lock_reg;
  endproperty
  a_relock: assert property (p_relock)                // [R2]
    else $error("lock not regained after relock");

endmodule : ccsp_top

/* File: sim/ccsp_host_model.sv */
`timescale 1ns/1ns
module ccsp_host_model (
  // Serial lines driven by the host
  output logic      sclk,
  output logic      sdi,
  output logic      serial_select_n,
  // Device answer
  input  wire logic sdo,
  input  wire logic sdo_oe
);
  logic [7:0] rd_byte;
  event       rd_done;

  // Idle state: clock parked low, select released
  initial begin
    sclk            = 1'b0;
    sdi             = 1'b0;
    serial_select_n = 1'b1;
    rd_byte         = 8'h00;
  end

  // One access, MSB first; fewer than 16 clocks leaves it unfinished
  task automatic frame(input logic [15:0] word, input int nclk);
    #3 serial_select_n = 1'b0;
    for (int i = 0; i < nclk; i++) begin
      #40 sclk = 1'b0;
      sdi = word[15 - i];
      #40 sclk = 1'b1;
      if (i >= 8) begin
        rd_byte = {rd_byte[6:0], sdo_oe ? sdo : 1'bz};
      end
    end
    #40 sclk = 1'b0;
    #40 serial_select_n = 1'b1;
    sdi = ~sdi;
    if (nclk == 16 && word[15]) begin
      -> rd_done;
    end
    #300 sdi = ~sdi; // Spacing keeps commits apart while mclk runs
  endtask : frame
endmodule : ccsp_host_model

/* File: sim/ccsp_top_test.sv */
`timescale 1ns/1ns
module ccsp_top_test;
  import ccsp_pkg::*;
  logic        mclk, rst, sclk, sdi, ssn, sdo, sdo_oe;
  logic        word_strobe, lock_lost_evt, dll_lock, lt;
  ccsp_pins_s  pdrv, pins;
  ccsp_chan_s  chan_in [2];
  ccsp_ctrl_s  eff_ctrl;
  logic [1:0]  held_addr, overrange, lane_one_out, lane_zero_out;
  logic [1:0]  lane_zero_oe;
  logic [7:0]  c, ph, pl;
  logic [13:0] w;
  logic [15:0] exp_q [$];
  int          err_count, n_tests, n;

  // Select pin copy follows the host's select
  always_comb begin
    pins                 = pdrv;
    pins.serial_select_n = ssn;
  end

  ccsp_top ccsp_top_i (.mclk(mclk), .rst(rst), .sclk(sclk), .sdi(sdi),
    .serial_select_n(ssn), .sdo(sdo), .sdo_oe(sdo_oe), .pins(pins),
    .word_strobe(word_strobe), .chan_in(chan_in),
    .lock_lost_evt(lock_lost_evt), .eff_ctrl(eff_ctrl),
    .held_addr(held_addr), .dll_lock(dll_lock), .overrange(overrange),
    .lane_one_out(lane_one_out), .lane_zero_out(lane_zero_out),
    .lane_zero_oe(lane_zero_oe));

  ccsp_host_model ccsp_host_model_i (.sclk(sclk), .sdi(sdi),
    .serial_select_n(ssn), .sdo(sdo), .sdo_oe(sdo_oe));

  // Converter clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic final_report();
    if (err_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  task automatic cmp(input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("BAD t=%0t expected %h got %h", $time, e, g);
    end
  endtask : cmp

  task automatic cyc(input int k);
    repeat (k) @(negedge mclk);
  endtask : cyc

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(negedge mclk);
    ccsp_host_model_i.frame({1'b0, 5'h00, a, d}, 16);
  endtask : wr

  // Read with a nonzero data byte, which the device must ignore
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    exp_q.push_back({8'h00, e});
    @(negedge mclk);
    ccsp_host_model_i.frame({1'b1, 5'h00, a, 8'h5a}, 16);
  endtask : rd

  // Count cycles until the lock output rises
  task automatic wait_lock(input int lo, input int hi);
    n = 0;
    while (dll_lock !== 1'b1 && n < 700) begin
      @(negedge mclk);
      n++;
    end
    lt = (n >= lo) && (n <= hi);
    cmp(16'h1, {15'h0, lt});
  endtask : wait_lock

  // One word from the core, then search channel A's lanes for it
  task automatic lane_chk(input logic [7:0] cv, input logic [13:0] e);
    logic [19:0] s;
    logic [19:0] z;
    logic        hit;
    int          al;
    s   = '0;
    z   = '0;
    hit = 1'b0;
    al  = (cv[2] && !cv[5]) ? 1 : 0;
    wr(ADDR_CTRL, cv);
    @(negedge mclk);
    chan_in[0]  = '{word: w, over: 1'b1};
    chan_in[1]  = '{word: ~w, over: 1'b0};
    word_strobe = 1'b1;
    @(negedge mclk);
    word_strobe = 1'b0;
    for (int i = 0; i < 20; i++) begin
      s = {s[18:0], lane_one_out[0]};
      z = {z[18:0], lane_zero_out[0]};
      @(negedge mclk);
    end
    for (int k = 1; k <= 12; k++) begin
      if (cv[5] && k <= 6) begin
        hit = hit | (s[k +: 14] === e);
      end else if (!cv[5]) begin
        hit = hit | (s[k - al +: 7] === e[13:7] && z[k +: 7] === e[6:0]);
      end
    end
    cmp(16'h1, {15'h0, hit});
    cmp({14'h0, cv[5] ? 2'b00 : 2'b11}, {14'h0, lane_zero_oe});
    if (cv[7:6] == MODE_NORMAL) begin
      cmp(16'h1, {14'h0, overrange});
    end
  endtask : lane_chk

  // Result watcher: each finished read is matched to the oldest note
  initial begin
    forever begin
      @(ccsp_host_model_i.rd_done);
      cmp(exp_q.size() > 0 ? exp_q.pop_front() : 16'hxxxx,
          {8'h00, ccsp_host_model_i.rd_byte});
    end
  end

  // Watchdog
  initial begin
    #400000;
    err_count++;
    final_report();
  end

  // Main sequence
  initial begin
    void'($urandom(32'h600fc8cc));
    err_count           = 0;
    n_tests             = 0;
    rst                 = 1'b1;
    word_strobe         = 1'b0;
    lock_lost_evt       = 1'b0;
    pdrv                = '0;
    pdrv.serial_enable  = 1'b1;
    chan_in[0]          = '0;
    chan_in[1]          = '0;
    w                   = 14'h0000;
    ph                  = 8'h00;
    pl                  = 8'h00;
    cyc(12);
    rst = 1'b0;
    cmp({14'h0, ADDR_RESET}, {14'h0, held_addr});
    wait_lock(DLL_LOCK_CYC - 2, DLL_LOCK_CYC + 4);
    rd(ADDR_CTRL, CTRL_RESET);
    rd(ADDR_PAT_HI, 8'h00);
    rd(ADDR_PAT_LO, PAT_LO_RESET);
    cmp(16'h2, {14'h0, held_addr});
    wr(2'h3, 8'hff);
    rd(2'h3, 8'h00);
    for (int k = 0; k < 4; k++) begin
      c  = 8'($urandom);
      ph = {2'b00, 6'($urandom)};
      pl = 8'($urandom);
      c[7] = c[7] & ~c[6];
      if (c[5]) begin
        c[2] = 1'b0;
      end
      wr(ADDR_CTRL, c);
      wr(ADDR_PAT_HI, ph);
      wr(ADDR_PAT_LO, pl);
      rd(ADDR_CTRL, c);
      rd(ADDR_PAT_HI, ph);
      rd(ADDR_PAT_LO, pl);
      @(negedge mclk);
      pdrv = ccsp_pins_s'(10'($urandom));
      pdrv.serial_enable = 1'b1;
      pdrv.dll_relock    = 1'b0;
      cyc(8);
      cmp({8'h00, c}, {8'h00, eff_ctrl});
    end
    // Unfinished write must change neither address nor register
    @(negedge mclk);
    ccsp_host_model_i.frame({1'b0, 5'h00, ADDR_PAT_HI, 8'h3f}, 10);
    cmp(16'h2, {14'h0, held_addr});
    rd(ADDR_PAT_HI, ph);
    w = 14'($urandom);
    lane_chk(8'h60, FIXED_PATTERN);
    lane_chk(8'ha0, {ph[5:0], pl});
    lane_chk(8'h20, w);
    lane_chk(8'h28, {~w[13], w[12:0]});
    lane_chk(8'h40, FIXED_PATTERN);
    lane_chk(8'h44, FIXED_PATTERN);
    // Direct pins govern with the serial port disabled
    for (int k = 0; k < 6; k++) begin
      @(negedge mclk);
      pdrv = ccsp_pins_s'(10'($urandom));
      pdrv.serial_enable = 1'b0;
      pdrv.dll_relock    = 1'b0;
      if (pdrv.lane_config_sel) begin
        pdrv.word_align_sel = 1'b0;
      end
      cyc(8);
      cmp({8'h00, pdrv.test_pin ? MODE_FIXED : MODE_NORMAL,
           pdrv.lane_config_sel, pdrv.format_stabilizer_pin[0],
           pdrv.format_stabilizer_pin[1], pdrv.word_align_sel,
           pdrv.powerdown_chan_a, pdrv.powerdown_chan_b},
          {8'h00, eff_ctrl});
    end
    pdrv.dll_relock = 1'b1;
    cyc(100);
    cmp(16'h0, {15'h0, dll_lock});
    pdrv.dll_relock = 1'b0;
    wait_lock(DLL_LOCK_CYC - 2, DLL_LOCK_CYC + 8);
    lock_lost_evt = 1'b1;
    cyc(1);
    lock_lost_evt = 1'b0;
    cyc(4);
    cmp(16'h0, {15'h0, dll_lock});
    cyc(20);
    cmp(16'h0, 16'(exp_q.size()));
    final_report();
  end
endmodule : ccsp_top_test
